// ---- include/module_expansion_bus_pkg.sv ----
// Summary of operation
// - slave mode: host reaches module; master mode: module dma reaches shared dram
// - board timeout ends unanswered region accesses; module must not rely on it
// - dram holds data and ready until extend negated with ready and burst last
// - extend stays inactive in slave cycles; only meaningful with module as master
// - module reset asserted after power-up and held at least 200 ms
// - module requests with bus request; arbiter answers with bus grant
// - all interface signals timed on rising edges of the reference clock
// - master asserts lock during an atomic read-modify-write sequence
// - address strobe asserted for exactly the first clock of each access
// - region select sets on strobe with region address, clears on last plus ready; the code sets it only while bus grant is negated
// - burst last marks final transfer and stays until ready ends it
// - write_not_read low for reads, high for writes, from the master's view
package module_expansion_bus_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int RESET_HOLD_MS = 200;
  localparam int RESET_HOLD_CYCLES = (CLK_HZ / 1000) * RESET_HOLD_MS;
  localparam int DRAM_WAIT_CYCLES = 2;
  localparam int TIMEOUT_CYCLES = 64;

  // ----------------------------------------
  // address map
  // ----------------------------------------
  localparam logic [3:0] REGION_TOP_NIBBLE = 4'hc;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic addrStrobeN;
    logic burstLastN;
    logic writeNotRead;
    logic atomicLockN;
    logic readHoldExtendN;
  } busCtl_type;

  typedef enum logic [1:0] {
    DRAM_IDLE = 2'b00,
    DRAM_WAIT = 2'b01,
    DRAM_XFER = 2'b11
  } dramState_type;

endpackage

// ---- rtl/module_expansion_bus.sv ----
`timescale 1ns/1ps
`default_nettype none
module module_expansion_bus
  import module_expansion_bus_pkg::*;
#(
  parameter int ResetHoldCycles = RESET_HOLD_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  input wire busCtl_type busCtl,
  input wire logic [31:28] busAddrTop,
  input wire logic moduleReadyN,
  input wire logic [31:0] dramReadData,
  input wire logic hostBusIdle,
  input wire logic shared_bus_request_n,
  input wire logic module_irq0_n,
  input wire logic module_irq1_n,
  output logic module_region_select_n,
  output logic shared_bus_grant_n,
  output logic dramReadyN,
  output logic [31:0] dramDataOut,
  output logic dramDataOe,
  output logic timeoutReadyN,
  output logic moduleResetN,
  output logic host_ext_irq_line_four,
  output logic host_ext_irq_line_three,
  output logic extendMisuse
);

  // ----------------------------------------
  // shared ready line
  // ----------------------------------------
  // ready is a wired-or of low drivers: module slave, board timeout, dram
  logic busReadyN;
  logic lastBeat;
  assign busReadyN = moduleReadyN & timeoutReadyN & dramReadyN;
  assign lastBeat = !busCtl.burstLastN && !busReadyN;

  // ----------------------------------------
  // module reset stretch
  // ----------------------------------------
  logic [31:0] resetCount_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      resetCount_q <= 32'h0;
      moduleResetN <= 1'b0;
    end else if (resetCount_q < 32'(ResetHoldCycles)) begin
      resetCount_q <= resetCount_q + 32'h1;
      moduleResetN <= 1'b0;
    end else begin
      moduleResetN <= 1'b1;
    end
  end

  // ----------------------------------------
  // region select
  // ----------------------------------------
  logic regionHit;
  assign regionHit = !busCtl.addrStrobeN && busAddrTop == REGION_TOP_NIBBLE &&
                     shared_bus_grant_n;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      module_region_select_n <= 1'b1;
    end else if (regionHit) begin
      module_region_select_n <= 1'b0;
    end else if (!module_region_select_n && lastBeat) begin
      module_region_select_n <= 1'b1;
    end
  end

  // ----------------------------------------
  // unanswered access timeout
  // ----------------------------------------
  // safety net only: a well behaved module answers long before this
  logic [7:0] waitCount_q;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitCount_q <= 8'h0;
      timeoutReadyN <= 1'b1;
    end else if (module_region_select_n || !busReadyN) begin
      waitCount_q <= 8'h0; // any wait length restarts per beat
      timeoutReadyN <= 1'b1;
    end else if (waitCount_q == 8'(TIMEOUT_CYCLES - 1)) begin
      waitCount_q <= 8'h0;
      timeoutReadyN <= 1'b0;
    end else begin
      waitCount_q <= waitCount_q + 8'h1;
      timeoutReadyN <= 1'b1;
    end
  end

  // ----------------------------------------
  // shared bus arbiter
  // ----------------------------------------
  // grant is held while locked so an atomic sequence is never split
  always_ff @(posedge clk) begin
    if (!rstn) begin
      shared_bus_grant_n <= 1'b1;
    end else if (!shared_bus_request_n && hostBusIdle && module_region_select_n) begin
      shared_bus_grant_n <= 1'b0;
    end else if (shared_bus_request_n && busCtl.atomicLockN) begin
      shared_bus_grant_n <= 1'b1;
    end
  end

  // ----------------------------------------
  // dram controller for module master
  // ----------------------------------------
  dramState_type dramState_q;
  logic [1:0] dramWait_q;
  logic singleRead_q;
  logic masterStart;
  logic holdForExtend;
  assign masterStart = !shared_bus_grant_n && !busCtl.addrStrobeN;
  // extend is honoured only on single reads with the module as master
  assign holdForExtend = singleRead_q && !busCtl.readHoldExtendN;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      dramState_q <= DRAM_IDLE;
      dramWait_q <= 2'h0;
      singleRead_q <= 1'b0;
      dramReadyN <= 1'b1;
      dramDataOut <= 32'h0;
      dramDataOe <= 1'b0;
    end else begin
      case (dramState_q)
        DRAM_IDLE: begin
          dramReadyN <= 1'b1;
          dramDataOe <= 1'b0;
          if (masterStart) begin
            dramState_q <= DRAM_WAIT;
            dramWait_q <= 2'(DRAM_WAIT_CYCLES - 1);
            singleRead_q <= !busCtl.burstLastN && !busCtl.writeNotRead;
            dramDataOe <= !busCtl.writeNotRead;
          end
        end
        DRAM_WAIT: begin
          if (dramWait_q == 2'h0) begin
            dramState_q <= DRAM_XFER;
            dramReadyN <= 1'b0;
            dramDataOut <= dramReadData;
          end else begin
            dramWait_q <= dramWait_q - 2'h1;
          end
        end
        DRAM_XFER: begin
          if (holdForExtend) begin
            dramReadyN <= 1'b0; // data and ready stay put
          end else if (!busCtl.burstLastN) begin
            dramState_q <= DRAM_IDLE;
            dramReadyN <= 1'b1;
            dramDataOe <= 1'b0;
          end else begin
            dramState_q <= DRAM_WAIT;
            dramWait_q <= 2'(DRAM_WAIT_CYCLES - 1);
            dramReadyN <= 1'b1;
          end
        end
        default: begin
          dramState_q <= DRAM_IDLE;
          dramReadyN <= 1'b1;
          dramDataOe <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // extend misuse monitor
  // ----------------------------------------
  // sticky until reset; extend in slave, burst or write cycles corrupts dram
  always_ff @(posedge clk) begin
    if (!rstn) begin
      extendMisuse <= 1'b0;
    end else if (!busCtl.readHoldExtendN &&
                 (shared_bus_grant_n || (dramState_q != DRAM_IDLE && !singleRead_q))) begin
      extendMisuse <= 1'b1;
    end
  end

  // ----------------------------------------
  // interrupt routing
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      host_ext_irq_line_four <= 1'b1;
      host_ext_irq_line_three <= 1'b1;
    end else begin
      host_ext_irq_line_four <= module_irq0_n;
      host_ext_irq_line_three <= module_irq1_n;
    end
  end

endmodule // module_expansion_bus
`default_nettype wire

// ---- verif/module_expansion_bus_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module module_expansion_bus_assertions
  import module_expansion_bus_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire busCtl_type busCtl,
  input wire logic [31:28] busAddrTop,
  input wire logic moduleReadyN,
  input wire logic hostBusIdle,
  input wire logic shared_bus_request_n,
  input wire logic module_region_select_n,
  input wire logic shared_bus_grant_n,
  input wire logic dramReadyN,
  input wire logic timeoutReadyN
);
  logic sel, gnt, stb, lst, rdy;
  assign sel = !module_region_select_n;
  assign gnt = !shared_bus_grant_n;
  assign stb = !busCtl.addrStrobeN;
  assign lst = !busCtl.burstLastN;
  assign rdy = !(moduleReadyN & timeoutReadyN & dramReadyN);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence regionHit;
    stb && busAddrTop == REGION_TOP_NIBBLE && !gnt && !sel;
  endsequence
  a_sel_set: assert property (regionHit |=> sel)
    else $error("select not raised");
  a_sel_clear: assert property (sel && lst && rdy |=> !sel)
    else $error("select not dropped");
  a_sel_bound: assert property ($rose(sel) |-> ##[1:80] !sel)
    else $error("access never ended");
  a_grant_set: assert property (
    !shared_bus_request_n && hostBusIdle && !sel && !gnt |=> gnt) else $error("no grant");
  a_grant_busy: assert property (!hostBusIdle && !gnt |=> !gnt)
    else $error("grant while busy");
  a_lock_hold: assert property (gnt && !busCtl.atomicLockN |=> gnt)
    else $error("grant lost under lock");
  a_dram_wait: assert property (
    gnt && stb && !busCtl.writeNotRead && dramReadyN |-> ##3 !dramReadyN) else $error("late");
  a_ext_hold: assert property (
    gnt && !dramReadyN && lst && !busCtl.writeNotRead && !busCtl.readHoldExtendN |=> !dramReadyN)
    else $error("extend not held");
endmodule // module_expansion_bus_assertions
`default_nettype wire

// ---- verif/module_slave_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module module_slave_model (
  input wire logic clk,
  input wire logic module_region_select_n,
  input wire logic [7:0] waitCycles,
  output logic moduleReadyN
);
  logic [7:0] cnt_q;
  // 8'hff plays a dead slave, so only the board timeout can end it
  assign moduleReadyN = module_region_select_n || cnt_q != waitCycles || &waitCycles;
  always_ff @(posedge clk) begin
    if (module_region_select_n || !moduleReadyN) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // module_slave_model
`default_nettype wire

// ---- verif/tb_module_expansion_bus.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_module_expansion_bus;
  import module_expansion_bus_pkg::*;
  logic clk = 1'h0, rstn = 1'h0, hostBusIdle = 1'h1, shared_bus_request_n = 1'h1;
  logic module_irq0_n = 1'h1, module_irq1_n = 1'h1, moduleReadyN, module_region_select_n;
  logic shared_bus_grant_n, dramReadyN, dramDataOe, timeoutReadyN, moduleResetN;
  logic host_ext_irq_line_four, host_ext_irq_line_three, extendMisuse;
  busCtl_type busCtl = 5'h1f;
  logic [31:28] busAddrTop = 4'h0;
  logic [7:0] waitCycles = 8'h03;
  logic [31:0] dramReadData = 32'h0, dramDataOut;
  int mismatches, n_compared, n;
  module_expansion_bus #(.ResetHoldCycles(20)) dut (.*);
  module_slave_model partner (.*);
  always #50 clk = ~clk;
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // k: 0 grant, 1 timeout, 2 dram ready, 3 select
  task automatic waitLvl(input int k, input logic v);
    logic [3:0] s;
    for (n = 1; n < 100; n++) begin
      @(posedge clk);
      #1;
      s = {module_region_select_n, dramReadyN, timeoutReadyN, shared_bus_grant_n};
      if (s[k] === v) return;
    end
    chk("wait bound", 0, 1);
    end_sim();
  endtask
  task automatic drive(input logic [4:0] c, input logic [3:0] a);
    @(posedge clk);
    busCtl <= c;
    busAddrTop <= a;
  endtask
  task automatic t_slave();
    for (int w = 0; w < 4; w += 3) begin
      drive(5'h03, 4'hc);
      waitCycles <= 8'(w);
      drive(5'h13, 4'hc);
      #1;
      chk("select set", 0, module_region_select_n);
      waitLvl(3, 1'h1);
      chk("slave length", 1, n <= w + 4);
      drive(5'h1f, 4'h0);
    end
  endtask
  task automatic t_timeout();
    drive(5'h03, 4'hc);
    waitCycles <= 8'hff;
    drive(5'h13, 4'hc);
    waitLvl(3, 1'h0);
    waitLvl(1, 1'h0);
    chk("timeout wait", 1, n > 60);
    waitLvl(3, 1'h1);
    drive(5'h03, 4'h8);
    drive(5'h13, 4'h8);
    repeat (3) @(posedge clk);
    #1;
    chk("outside region", 1, module_region_select_n);
  endtask
  task automatic t_master();
    drive(5'h1f, 4'h0);
    hostBusIdle <= 1'h0;
    shared_bus_request_n <= 1'h0;
    repeat (4) @(posedge clk);
    #1;
    chk("grant while busy", 1, shared_bus_grant_n);
    drive(5'h1f, 4'h0);
    hostBusIdle <= 1'h1;
    waitLvl(0, 1'h0);
    drive(5'h02, 4'h0);
    dramReadData <= 32'ha5c3_0f1e;
    drive(5'h12, 4'h0);
    waitLvl(2, 1'h0);
    chk("read wait", 32'(DRAM_WAIT_CYCLES), n);
    chk("read enable", 1, dramDataOe);
    chk("read data", 32'ha5c3_0f1e, dramDataOut);
    repeat (3) @(posedge clk);
    #1;
    chk("extended ready", 0, dramReadyN);
    drive(5'h13, 4'h0);
    waitLvl(2, 1'h1);
    drive(5'h06, 4'h0);
    drive(5'h16, 4'h0);
    waitLvl(2, 1'h0);
    chk("write enable", 0, dramDataOe);
    drive(5'h1d, 4'h0);
    shared_bus_request_n <= 1'h1;
    module_irq0_n <= 1'h0;
    module_irq1_n <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("extend misuse", 1, extendMisuse);
    chk("grant under lock", 0, shared_bus_grant_n);
    chk("irq lines", 0, {host_ext_irq_line_four, host_ext_irq_line_three});
    drive(5'h1f, 4'h0);
    waitLvl(0, 1'h1);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    #1;
    chk("reset to module", 0, moduleResetN);
    @(posedge clk);
    rstn <= 1'h1;
    repeat (15) @(posedge clk);
    #1;
    chk("reset hold", 0, moduleResetN);
    repeat (10) @(posedge clk);
    #1;
    chk("reset release", 1, moduleResetN);
    t_slave();
    t_timeout();
    t_master();
    end_sim();
  end
endmodule // tb_module_expansion_bus
bind module_expansion_bus module_expansion_bus_assertions checker_i (.*);
`default_nettype wire
